// ---- hw/pwr_seq_pkg.sv ----
/*
 Package for the power on/off and reboot sequencer: timing constants,
 state encoding and the pad/status carriers.
 Assumes a 10 MHz system clock.
*/
package pwr_seq_pkg;

   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned TOGGLE_MIN_MS = 1000;
   localparam int unsigned REBOOT_MIN_MS = 200;
   localparam int unsigned MS_PER_S = 1000;
   localparam int unsigned TOGGLE_MIN_CYC = (CLK_HZ / MS_PER_S) * TOGGLE_MIN_MS;
   localparam int unsigned REBOOT_MIN_CYC = (CLK_HZ / MS_PER_S) * REBOOT_MIN_MS;
   localparam int unsigned CNT_W = 24;
   localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
   localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;

   typedef enum logic [2:0]
   {
      ST_OFF = 3'b000,
      ST_ON = 3'b001,
      ST_DETACH = 3'b010,
      ST_REBOOT = 3'b011
   } pwr_state_e;

   // Pads as seen at the device pins, active low, open collector
   typedef struct packed
   {
      logic power_toggle_n;
      logic reboot_n;
   } pads_s;

   // Supply sense inputs
   typedef struct packed
   {
      logic charger_present;
      logic battery_present;
   } supply_s;

endpackage

// ---- hw/low_pulse_qual.sv ----
/*
 Qualifies a synchronised active-low pad: a pulse that stays low for at
 least MIN_CYC cycles gives a one-cycle strobe on its release.
 Assumes the pad input is already synchronised to clk.
*/
module low_pulse_qual
   import pwr_seq_pkg::*;
#(
   parameter int unsigned MIN_CYC = TOGGLE_MIN_CYC
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Pad level and result
   input wire logic pad_n,
   output logic released_long
);

   localparam logic [CNT_W-1:0] MIN_CNT = CNT_W'(MIN_CYC);

   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic strobe_r;
   logic strobe_nxt;

   always_comb
   begin
      cnt_nxt = cnt_r;
      strobe_nxt = 1'b0;
      if (!pad_n)
      begin
         if (cnt_r < MIN_CNT)
         begin
            cnt_nxt = cnt_r + CNT_ONE;
         end
      end
      else
      begin
         // Short pulses are dropped here
         strobe_nxt = (cnt_r >= MIN_CNT);
         cnt_nxt = CNT_ZERO;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt_r <= CNT_ZERO;
         strobe_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         strobe_r <= strobe_nxt;
      end
   end

   assign released_long = strobe_r;

endmodule

// ---- hw/power_onoff_ctrl.sv ----
/*
 Power on/off and unconditional reboot sequencer of the module.
 Assumes host drives the pads open collector; pad inputs come from
 another domain and are synchronised here.
 Pulse minimums count clk cycles, so the defaults assume 10 MHz.
*/
// What this block does
// - Pad held low one second then released powers the module on.
// - Hardware shutdown starts only after the pad is released.
// - Software command or hardware pulse both lead to power-off.
// - A network detach request is sent before any shutdown completes.
// - Power state indicator goes low once fully powered off.
// - Reboot pad low at least 200 ms then released reboots unconditionally.
// - Charger power with battery present powers the module on.
// - Toggle pad is pulled high internally; host drives open collector only.
module power_onoff_ctrl
   import pwr_seq_pkg::*;
#(
   parameter int unsigned TOGGLE_CYC = TOGGLE_MIN_CYC,
   parameter int unsigned REBOOT_CYC = REBOOT_MIN_CYC
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Pads and supply sense
   input pads_s pads,
   input supply_s supply,
   // Software shutdown and network detach handshake
   input wire logic sw_shutdown,
   output logic detach_req,
   input wire logic detach_done,
   // Power outputs
   output logic power_state_indicator,
   output logic core_reset_n,
   output logic toggle_pullup_en
);

   pads_s pads_s1_r;
   pads_s pads_s2_r;
   supply_s sup_s1_r;
   supply_s sup_s2_r;
   logic charge_d_r;
   logic charge_nxt;
   logic toggle_ev;
   logic reboot_ev;
   logic charge_rise;
   pwr_state_e state_r;
   pwr_state_e state_nxt;
   logic ind_r;
   logic ind_nxt;
   logic det_r;
   logic det_nxt;
   logic crst_r;
   logic crst_nxt;

   // Core supplied in every state but off
   function automatic logic is_live(input pwr_state_e st);
      return st != ST_OFF;
   endfunction

   // Core out of reset except when off or rebooting
   function automatic logic core_runs(input pwr_state_e st);
      return is_live(st) && (st != ST_REBOOT);
   endfunction

   // Pad synchroniser, idle high like the pulled-up pads
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pads_s1_r <= '1;
         pads_s2_r <= '1;
      end
      else
      begin
         pads_s1_r <= pads;
         pads_s2_r <= pads_s1_r;
      end
   end

   // Supply sense synchroniser
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sup_s1_r <= '0;
         sup_s2_r <= '0;
      end
      else
      begin
         sup_s1_r <= supply;
         sup_s2_r <= sup_s1_r;
      end
   end

   // Internal pull-up on the toggle pad is always enabled
   assign toggle_pullup_en = 1'b1;

   // Toggle and reboot pulse qualifiers
   low_pulse_qual #(
      .MIN_CYC(TOGGLE_CYC)
   ) u_toggle (
      .clk(clk),
      .nrst(nrst),
      .pad_n(pads_s2_r.power_toggle_n),
      .released_long(toggle_ev)
   );

   low_pulse_qual #(
      .MIN_CYC(REBOOT_CYC)
   ) u_reboot (
      .clk(clk),
      .nrst(nrst),
      .pad_n(pads_s2_r.reboot_n),
      .released_long(reboot_ev)
   );

   assign charge_nxt = sup_s2_r.charger_present & sup_s2_r.battery_present;
   assign charge_rise = charge_nxt & ~charge_d_r;

   // Charger edge detector, idle level matches the synchroniser reset
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         charge_d_r <= 1'b0;
      end
      else
      begin
         charge_d_r <= charge_nxt;
      end
   end

   // Sequencer transitions
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_OFF:
         begin
            if (toggle_ev || charge_rise)
            begin
               state_nxt = ST_ON;
            end
         end
         ST_ON:
         begin
            if (reboot_ev)
            begin
               state_nxt = ST_REBOOT;
            end
            else if (toggle_ev || sw_shutdown)
            begin
               state_nxt = ST_DETACH;
            end
         end
         ST_DETACH:
         begin
            // Off only once the network has the detach
            if (reboot_ev)
            begin
               state_nxt = ST_REBOOT;
            end
            else if (detach_done)
            begin
               state_nxt = ST_OFF;
            end
         end
         ST_REBOOT:
         begin
            // One cycle of core reset, then running again
            state_nxt = ST_ON;
         end
         default:
         begin
            state_nxt = ST_OFF;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_r <= ST_OFF;
      end
      else
      begin
         state_r <= state_nxt;
      end
   end

   // Outputs follow the next state so they change with it
   always_comb
   begin
      ind_nxt = is_live(state_nxt);
      det_nxt = (state_nxt == ST_DETACH);
      crst_nxt = core_runs(state_nxt);
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ind_r <= 1'b0;
         det_r <= 1'b0;
         crst_r <= 1'b0;
      end
      else
      begin
         ind_r <= ind_nxt;
         det_r <= det_nxt;
         crst_r <= crst_nxt;
      end
   end

   assign power_state_indicator = ind_r;
   assign detach_req = det_r;
   assign core_reset_n = crst_r;

endmodule

// ---- verif/host_side_model.sv ----
/*
 Host side: open-collector pad drivers and a network peer that answers detach.
 Assumes the device pulls the toggle pad high internally.
*/
module host_side_model
   import pwr_seq_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Host transistor controls
   input wire logic pull_tog,
   input wire logic pull_rst,
   input wire logic slow,
   // Pads and network
   input wire logic detach_req,
   output pads_s pads,
   output logic detach_done
);
   timeunit 1ns;
   timeprecision 1ns;
   int wait_r;
   // Low only while pulled, else pulled up
   assign pads = {~pull_tog, ~pull_rst};
   assign detach_done = detach_req && wait_r >= (slow ? 30 : 2);
   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
         wait_r <= 0;
      else
         wait_r <= detach_req ? wait_r + 1 : 0;
endmodule

// ---- verif/power_onoff_ctrl_chk.sv ----
/*
 Checker of the sequencer outputs.
 Assumes it is bound to power_onoff_ctrl.
*/
module power_onoff_ctrl_chk
   import pwr_seq_pkg::*;
#(
   parameter int unsigned TOGGLE_CYC = TOGGLE_MIN_CYC,
   parameter int unsigned REBOOT_CYC = REBOOT_MIN_CYC
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Inputs
   input pads_s pads,
   input supply_s supply,
   input wire logic sw_shutdown,
   input wire logic detach_done,
   // Outputs
   input wire logic detach_req,
   input wire logic power_state_indicator,
   input wire logic core_reset_n,
   input wire logic toggle_pullup_en
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   chk_pullup_on: assert property (toggle_pullup_en) else $error("pull-up off");
   chk_held_no_stop: assert property ($rose(detach_req) |-> $past(pads.power_toggle_n, 2) || $past(sw_shutdown))
      else $error("stop while pad held");
   chk_detach_first: assert property ($fell(power_state_indicator) |-> $past(detach_req))
      else $error("off without detach");
   chk_done_off: assert property (detach_req && detach_done |=> !power_state_indicator && !detach_req)
      else $error("not off after detach");
   chk_off_core: assert property (!power_state_indicator && !detach_req |-> !core_reset_n)
      else $error("core live while off");
   chk_reboot_pulse: assert property ($fell(core_reset_n) && power_state_indicator |=> core_reset_n)
      else $error("reboot pulse long");
   chk_charger_on: assert property ($rose(supply.charger_present && supply.battery_present) &&
      !power_state_indicator && !detach_req |-> ##[1:6] power_state_indicator) else $error("no charger start");
   chk_on_core: assert property ($rose(power_state_indicator) |-> core_reset_n && !detach_req)
      else $error("bad power-on");
   cover property ($rose(power_state_indicator));
   cover property ($fell(power_state_indicator));
   cover property ($fell(core_reset_n) && power_state_indicator);
   cover property ($rose(detach_req));
   cover property ($fell(detach_req) && power_state_indicator);
endmodule
bind power_onoff_ctrl power_onoff_ctrl_chk #(.TOGGLE_CYC(TOGGLE_CYC), .REBOOT_CYC(REBOOT_CYC)) u_chk (.clk(clk),
   .nrst(nrst), .pads(pads), .supply(supply), .sw_shutdown(sw_shutdown), .detach_done(detach_done),
   .detach_req(detach_req), .power_state_indicator(power_state_indicator), .core_reset_n(core_reset_n),
   .toggle_pullup_en(toggle_pullup_en));

// ---- verif/testbench.sv ----
/*
 Bench for power_onoff_ctrl with random pulse lengths.
 Assumes shortened counts of 20 and 8 cycles.
*/
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import pwr_seq_pkg::*;
   localparam int TC = 20;
   localparam int RC = 8;
   logic clk = 0, nrst = 0, sw = 0, slow = 0, pt = 0, pr = 0;
   logic dreq, ddone, ind, crst, pu;
   pads_s pads;
   supply_s sup = 2'b00;
   int err_count = 0, n_compared = 0, rb = 0, dseen = 0, n, i;
   always #50 clk = ~clk;
   always @(posedge clk) rb += (ind && !crst);
   always @(posedge clk) dseen += dreq;
   power_onoff_ctrl #(.TOGGLE_CYC(TC), .REBOOT_CYC(RC)) u_power_onoff_ctrl (.clk(clk), .nrst(nrst), .pads(pads),
      .supply(sup), .sw_shutdown(sw), .detach_req(dreq), .detach_done(ddone), .power_state_indicator(ind),
      .core_reset_n(crst), .toggle_pullup_en(pu));
   host_side_model u_host_side_model (.clk(clk), .nrst(nrst), .pull_tog(pt), .pull_rst(pr), .slow(slow),
      .detach_req(dreq), .pads(pads), .detach_done(ddone));
   function automatic logic takes(int len, int min);
      return len >= min;
   endfunction
   task automatic check(logic got, logic exp);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD %0t got %b expected %b", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic press(logic tog, int len);
      pt = tog;
      pr = !tog;
      repeat (len) @(negedge clk);
      if (tog)
         check(dreq, 1'b0);
      pt = 0;
      pr = 0;
      repeat (8) @(negedge clk);
      $display("pulse of %0d done", len);
   endtask
   task automatic wait_ind(logic exp);
      for (i = 0; i < 40 && ind !== exp; i++)
         @(negedge clk);
      if (ind !== exp)
      begin
         err_count++;
         $display("BAD %0t indicator wait timed out", $time);
         complete_run();
      end
      else
         $display("state wait done");
   endtask
   task automatic sw_off();
      sw = 1;
      @(negedge clk);
      sw = 0;
      check(dreq, 1'b1);
   endtask
   initial
   begin
      void'($urandom(32));
      repeat (5) @(negedge clk);
      nrst = 1;
      check(pu, 1'b1);
      press(1, TC - 1 - $urandom % 5);
      check(ind, 1'b0);
      n = TC + $urandom % 10;
      press(1, n);
      check(ind, takes(n, TC));
      press(0, RC - 1);
      check(rb == 0, 1'b1);
      press(0, RC);
      check(rb == 1, 1'b1);
      check(ind, 1'b1);
      dseen = 0;
      press(1, TC - 1 - $urandom % 5);
      check(dseen == 0, 1'b1);
      check(ind, 1'b1);
      slow = 1;
      press(1, TC);
      wait_ind(1'b0);
      check(dseen > 0, 1'b1);
      check(crst, 1'b0);
      sup = 2'b11;
      wait_ind(1'b1);
      check(crst, 1'b1);
      sw_off();
      press(0, RC);
      check(rb == 2, 1'b1);
      check(dreq, 1'b0);
      check(ind, 1'b1);
      sw_off();
      wait_ind(1'b0);
      check(crst, 1'b0);
      complete_run();
   end
endmodule
